// ### rtl/esra_core.sv
// Two-wire EEPROM slave: array, ID page, serial number, protect and select-code registers
`timescale 1ns/10ps
`include "esra_regs.svh"
module esra_core
  import esra_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE_CYCLES = `ESRA_WRITE_CYCLE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic [127:0] I_SERIAL_NUM,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  output logic O_BUSY,
  output logic [2:0] O_DSC,
  output logic O_ID_LOCKED,
  output logic [3:0] O_SWP
);

  logic scl;
  logic sda;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  esra_state_t state_ff;
  logic [3:0] rx_cnt_ff;
  logic [7:0] shift_ff;
  logic [3:0] tx_cnt_ff;
  logic [7:0] tx_ff;
  logic sda_oe_ff;
  logic rw_ff;
  logic is_special_ff;
  logic ack_seen_ff;

  logic [15:0] addr_ff;
  logic [2:0] dsc_ff;
  logic lock_ff;
  logic [3:0] swp_ff;
  logic [3:0] swp_pend_ff;
  logic [1:0] swp_cnt_ff;
  logic wrote_ff;
  logic [31:0] busy_cnt_ff;
  logic [7:0] id_ff [`ESRA_ID_BYTES];

  logic rx_state;
  logic byte_rx;
  logic busy;
  logic addr_match;
  logic dev_ok;
  esra_region_t rg;
  logic wr_ack;
  logic wdat_acc;
  logic load_rd;
  logic prot_hit;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] sn_byte;
  logic [7:0] rd_data;

  // Decode the target of an access from the type bit and word address
  function automatic esra_region_t region_of(input logic special, input logic [15:0] a);
    esra_region_t r;
    r = RG_ARRAY;
    if (special) begin
      case (a[11:10])
        `ESRA_SEL_ID: r = RG_ID;
        `ESRA_SEL_LOCK: r = RG_LOCK;
        `ESRA_SEL_SERIAL: r = RG_SERIAL;
        default: r = RG_DSC;
      endcase
    end else if (a[`ESRA_SWP_ADDR_BIT]) begin
      r = RG_SWP;
    end
    return r;
  endfunction

  // Next counter value after one byte, per region and direction
  function automatic logic [15:0] adv_addr(input esra_region_t r, input logic [15:0] a, input logic wr);
    logic [15:0] n;
    n = a;
    case (r)
      RG_ARRAY: begin
        if (wr) begin
          n = {a[15:6], a[5:0] + 6'h1};
        end else begin
          n = {a[15:14], a[13:0] + 14'h1};
        end
      end
      RG_ID: n = {a[15:6], a[5:0] + 6'h1};
      RG_SERIAL: n = {a[15:5], a[4:0] + 5'h1};
      default: n = a;
    endcase
    return n;
  endfunction

  esra_sync u_scl_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_pin(I_SCL),
    .o_level(scl)
  );

  esra_sync u_sda_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_pin(I_SDA),
    .o_level(sda)
  );

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end

  assign scl_rise = scl & ~scl_d_ff;
  assign scl_fall = ~scl & scl_d_ff;
  assign start_det = scl & scl_d_ff & sda_d_ff & ~sda;
  assign stop_det = scl & scl_d_ff & ~sda_d_ff & sda;

  assign rx_state = (state_ff == ST_DEV) || (state_ff == ST_AHI) || (state_ff == ST_ALO) ||
                    (state_ff == ST_WDAT);
  assign byte_rx = rx_state && scl_fall && (rx_cnt_ff == 4'h8);
  assign busy = (busy_cnt_ff != 32'h0);
  assign addr_match = ((shift_ff[7:4] == `ESRA_TYPE_ARRAY) || (shift_ff[7:4] == `ESRA_TYPE_SPECIAL)) &&
                      (shift_ff[3:1] == dsc_ff);
  // Holding off the ack also keeps the protect register unread mid-cycle
  assign dev_ok = addr_match && !busy;
  assign rg = region_of(is_special_ff, addr_ff);
  assign prot_hit = swp_ff[3] && (addr_ff[13:12] >= (2'h3 - swp_ff[2:1]));
  assign mem_we = wdat_acc && (rg == RG_ARRAY) && !prot_hit;
  assign sn_byte = I_SERIAL_NUM[{~addr_ff[3:0], 3'h0} +: 8];

  // Data byte acknowledge per target; serial number is read-only
  always_comb begin
    case (rg)
      RG_ID: wr_ack = !lock_ff;
      RG_SERIAL: wr_ack = 1'b0;
      default: wr_ack = 1'b1;
    endcase
  end

  assign wdat_acc = (state_ff == ST_WDAT) && byte_rx && wr_ack;
  assign load_rd = scl_fall && (((state_ff == ST_DEV_ACK) && rw_ff) ||
                                ((state_ff == ST_RACK) && ack_seen_ff));

  always_comb begin
    case (rg)
      RG_ARRAY: rd_data = mem_rdata;
      RG_ID: rd_data = id_ff[addr_ff[5:0]];
      RG_SERIAL: rd_data = addr_ff[4] ? 8'h00 : sn_byte;
      RG_SWP: rd_data = {4'h0, swp_ff};
      RG_DSC: rd_data = {5'h00, dsc_ff};
      default: rd_data = 8'h00;
    endcase
  end

  esra_mem u_mem (
    .i_clk(I_CLK),
    .i_we(mem_we),
    .i_waddr(addr_ff[13:0]),
    .i_wdata(shift_ff),
    .i_raddr(addr_ff[13:0]),
    .o_rdata(mem_rdata)
  );

  // Receive shifter, samples SDA on SCL rise
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (start_det || byte_rx || !rx_state) begin
      rx_cnt_ff <= 4'h0;
    end else if (scl_rise && (rx_cnt_ff != 4'h8)) begin
      shift_ff <= {shift_ff[6:0], sda};
      rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end
  end

  // Protocol sequencer; SDA changes only on SCL fall
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_ff <= ST_IDLE;
      tx_cnt_ff <= 4'h0;
      tx_ff <= 8'hff;
      sda_oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      is_special_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ST_DEV;
      sda_oe_ff <= 1'b0;
    end else if (load_rd) begin
      tx_ff <= {rd_data[6:0], 1'b1};
      sda_oe_ff <= ~rd_data[7];
      tx_cnt_ff <= 4'h1;
      state_ff <= ST_RDAT;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_WAIT: begin
          sda_oe_ff <= 1'b0;
        end
        ST_DEV: begin
          if (byte_rx) begin
            if (dev_ok) begin
              state_ff <= ST_DEV_ACK;
              sda_oe_ff <= 1'b1;
              rw_ff <= shift_ff[0];
              is_special_ff <= shift_ff[4];
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_AHI;
          end
        end
        ST_AHI: begin
          if (byte_rx) begin
            state_ff <= ST_AHI_ACK;
            sda_oe_ff <= 1'b1;
          end
        end
        ST_AHI_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_ALO;
          end
        end
        ST_ALO: begin
          if (byte_rx) begin
            state_ff <= ST_ALO_ACK;
            sda_oe_ff <= 1'b1;
          end
        end
        ST_ALO_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_WDAT;
          end
        end
        ST_WDAT: begin
          if (byte_rx) begin
            state_ff <= ST_WDAT_ACK;
            sda_oe_ff <= wr_ack;
          end
        end
        ST_WDAT_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            state_ff <= sda_oe_ff ? ST_WDAT : ST_WAIT;
          end
        end
        ST_RDAT: begin
          if (scl_fall) begin
            if (tx_cnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b0;
              ack_seen_ff <= 1'b0;
              state_ff <= ST_RACK;
            end else begin
              sda_oe_ff <= ~tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b1};
              tx_cnt_ff <= tx_cnt_ff + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda) begin
              state_ff <= ST_WAIT;
            end else begin
              ack_seen_ff <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Address counter; every array, ID or serial byte sent or accepted moves it, so after STOP it is one past the last
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      addr_ff <= 16'h0000;
    end else if ((state_ff == ST_AHI) && byte_rx) begin
      addr_ff[15:8] <= shift_ff;
    end else if ((state_ff == ST_ALO) && byte_rx) begin
      addr_ff[7:0] <= shift_ff;
    end else if (wdat_acc) begin
      addr_ff <= adv_addr(rg, addr_ff, 1'b1);
    end else if (load_rd) begin
      addr_ff <= adv_addr(rg, addr_ff, 1'b0);
    end
  end

  // Select code, lock and protect register updates
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      dsc_ff <= `ESRA_DSC_RST;
      lock_ff <= 1'b0;
      swp_ff <= `ESRA_SWP_RST;
      swp_pend_ff <= `ESRA_SWP_RST;
      swp_cnt_ff <= 2'h0;
    end else if (stop_det) begin
      // A multi-byte protect write is discarded whole
      if ((swp_cnt_ff == 2'h1) && !swp_ff[0]) begin
        swp_ff <= swp_pend_ff;
      end
      swp_cnt_ff <= 2'h0;
    end else if (start_det) begin
      swp_cnt_ff <= 2'h0;
    end else if (wdat_acc) begin
      case (rg)
        RG_LOCK: begin
          if (shift_ff[`ESRA_LOCK_DATA_BIT]) begin
            lock_ff <= 1'b1;
          end
        end
        RG_DSC: begin
          if (!lock_ff) begin
            dsc_ff <= shift_ff[2:0];
          end
        end
        RG_SWP: begin
          swp_pend_ff <= shift_ff[3:0];
          if (swp_cnt_ff != 2'h3) begin
            swp_cnt_ff <= swp_cnt_ff + 2'h1;
          end
        end
        default: begin
          swp_cnt_ff <= swp_cnt_ff;
        end
      endcase
    end
  end

  // ID page storage, writable until locked
  always_ff @(posedge I_CLK) begin
    if (wdat_acc && (rg == RG_ID)) begin
      id_ff[addr_ff[5:0]] <= shift_ff;
    end
  end

  // Self-timed write cycle starts at the STOP after any accepted data byte
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wrote_ff <= 1'b0;
      busy_cnt_ff <= 32'h0;
    end else if (stop_det && wrote_ff) begin
      wrote_ff <= 1'b0;
      busy_cnt_ff <= WRITE_CYCLE_CYCLES;
    end else begin
      if (wdat_acc) begin
        wrote_ff <= 1'b1;
      end
      if (busy) begin
        busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
    end
  end

  // Open drain: only ever pulls low
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = sda_oe_ff;
  assign O_BUSY = busy;
  assign O_DSC = dsc_ff;
  assign O_ID_LOCKED = lock_ff;
  assign O_SWP = swp_ff;

endmodule // esra_core

// ### rtl/esra_regs.svh
// Constants for the serial EEPROM special-region slave
// How it works
// - Type 1011b with A11:A10 = 11 writes the select code; other address bits ignored.
// - After the ID page lock, select-code writes no longer change the code.
// - Select-code register: bits 2:0 writable, default 000; bits 7:3 read zero.
// - Address byte matches type 1011 or 1010, then select code, then R/W.
// - Reads start like writes with R/W set; current, random and sequential forms.
// - After STOP the address counter stands one past the last array, ID or serial byte accessed.
// - Current-address read sends the counter byte, increments, wraps at array end.
// - After acking a read address the device shifts out the current byte.
// - Each master acknowledge makes the device send the next byte, wrapping.
// - Master no-acknowledge then STOP ends a read; device stops driving data.
// - ID page read uses type 1011b, A11:A10 zero, A5:A0 select the byte.
// - Single-byte ID page write is acknowledged when unlocked, refused when locked.
// - Serial read uses type 1011b, A11:A10 = 10, A3:A0 index 16 bytes.
// - After 16 serial bytes come 16 zero bytes, then the address wraps.
// - Protect register read at word address with top bit set; bits 7:4 zero.
// - Reading the protect register repeatedly returns the same value.
// - Protect register is not returned while a write cycle runs.
// - Type 1011b with A11:A10 = 11 reads the select code in bits 2:0.
// - Matching device address is acknowledged; mismatch returns to standby silently.
// - ID lock: byte write type 1011b, A11:A10 = 01, data bit 1 set.
// - During a write cycle device addresses are not acknowledged.
`ifndef ESRA_REGS_SVH
`define ESRA_REGS_SVH

`define ESRA_TYPE_ARRAY 4'ha
`define ESRA_TYPE_SPECIAL 4'hb
`define ESRA_SEL_ID 2'h0
`define ESRA_SEL_LOCK 2'h1
`define ESRA_SEL_SERIAL 2'h2
`define ESRA_SEL_DSC 2'h3
`define ESRA_SWP_ADDR_BIT 15
`define ESRA_LOCK_DATA_BIT 1
`define ESRA_DSC_RST 3'h0
`define ESRA_SWP_RST 4'h0
`define ESRA_ARRAY_AW 14
`define ESRA_ARRAY_BYTES 16384
`define ESRA_ID_BYTES 64
`define ESRA_CLK_PERIOD_NS 25
`define ESRA_WRITE_CYCLE_TIME_NS 5000000
`define ESRA_WRITE_CYCLE_CYCLES (`ESRA_WRITE_CYCLE_TIME_NS / `ESRA_CLK_PERIOD_NS)

`endif

// ### rtl/esra_pkg.sv
// Types shared by the EEPROM special-region slave
package esra_pkg;

  typedef enum logic [2:0] {
    RG_ARRAY,
    RG_SWP,
    RG_ID,
    RG_LOCK,
    RG_SERIAL,
    RG_DSC
  } esra_region_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_DEV_ACK,
    ST_AHI,
    ST_AHI_ACK,
    ST_ALO,
    ST_ALO_ACK,
    ST_WDAT,
    ST_WDAT_ACK,
    ST_RDAT,
    ST_RACK,
    ST_WAIT
  } esra_state_t;

endpackage

// ### rtl/esra_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module esra_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // Idle bus is high, so reset to high to avoid a false START
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_ff <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign o_level = level_ff;

endmodule // esra_sync

// ### rtl/esra_mem.sv
// Main byte array held in flip-flops
`timescale 1ns/10ps
`include "esra_regs.svh"
module esra_mem (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [`ESRA_ARRAY_AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [`ESRA_ARRAY_AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_ff [`ESRA_ARRAY_BYTES];

  // Data storage only, so no reset; contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem_ff[i_raddr];

endmodule // esra_mem

// ### sim/esra_core_monitor.sv
// Port-level assertions for the EEPROM special-region slave
`timescale 1ns/10ps
module esra_core_monitor #(
  parameter int unsigned WRITE_CYCLE_CYCLES = 20
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic O_BUSY,
  input wire logic [2:0] O_DSC,
  input wire logic O_ID_LOCKED,
  input wire logic [3:0] O_SWP
);
  logic scl_q;
  logic sda_q;
  logic [7:0] stop_age;
  int unsigned busy_cnt;
  // Cycles since a STOP on the pins, saturating
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      stop_age <= 8'hff;
    end else begin
      scl_q <= I_SCL;
      sda_q <= I_SDA;
      if (I_SCL && scl_q && I_SDA && !sda_q) stop_age <= 8'h00;
      else if (stop_age != 8'hff) stop_age <= stop_age + 8'h01;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) busy_cnt <= 32'h0;
    else if (O_BUSY) busy_cnt <= busy_cnt + 32'h1;
    else busy_cnt <= 32'h0;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  open_drain_a: assert property (O_SDA_OUT == 1'b0)
    else $error("SDA driven high");
  reset_vals_a: assert property ($rose(I_RSTN) |-> O_DSC == 3'h0 && !O_ID_LOCKED && O_SWP == 4'h0)
    else $error("Register not at default after reset");
  lock_sticky_a: assert property (O_ID_LOCKED |=> O_ID_LOCKED)
    else $error("Lock released");
  dsc_frozen_a: assert property ($past(O_ID_LOCKED) |-> $stable(O_DSC))
    else $error("Select code changed while locked");
  swp_at_stop_a: assert property ($changed(O_SWP) |-> stop_age <= 8'h0a)
    else $error("Protect bits changed away from STOP");
  busy_at_stop_a: assert property ($rose(O_BUSY) |-> stop_age <= 8'h0a)
    else $error("Write cycle began away from STOP");
  busy_len_a: assert property ($fell(O_BUSY) |-> busy_cnt == WRITE_CYCLE_CYCLES)
    else $error("Write cycle length wrong");
  oe_scl_low_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("SDA changed while SCL high");
  busy_quiet_a: assert property (O_BUSY |-> !O_SDA_OE)
    else $error("SDA driven during write cycle");
  stop_release_a: assert property (stop_age == 8'h0a |-> !O_SDA_OE)
    else $error("SDA still driven after STOP");
  c_dsc: cover property ($changed(O_DSC));
  c_lock: cover property ($rose(O_ID_LOCKED));
  c_busy: cover property ($fell(O_BUSY));
endmodule // esra_core_monitor

bind esra_core esra_core_monitor #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) mon (
  .I_CLK(I_CLK),
  .I_RSTN(I_RSTN),
  .I_SCL(I_SCL),
  .I_SDA(I_SDA),
  .O_SDA_OUT(O_SDA_OUT),
  .O_SDA_OE(O_SDA_OE),
  .O_BUSY(O_BUSY),
  .O_DSC(O_DSC),
  .O_ID_LOCKED(O_ID_LOCKED),
  .O_SWP(O_SWP)
);

// ### sim/esra_master.sv
// Two-wire bus master model facing the EEPROM slave
`timescale 1ns/10ps
module esra_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Phase length in clocks; raise it to act as a slow master
  int hp = 10;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic half();
    repeat (hp) @(negedge i_clk);
  endtask
  // SDA moves mid low phase, or mid high phase for START and STOP; never with an SCL edge
  task automatic start();
    half();
    o_sda = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask
  task automatic bit_io(input logic b, output logic s);
    half();
    o_sda = b;
    half();
    o_scl = 1'b1;
    half();
    s = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule // esra_master

// ### sim/tb.sv
// Self-checking bench for the EEPROM special-region slave
`timescale 1ns/10ps
module tb;
  localparam int unsigned WCC = 400;
  logic I_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic [127:0] ser = 128'hc0c1c2c3c4c5c6c7c8c9cacbcccdcecf;
  logic m_scl, m_sda, sda, sda_out, sda_oe, busy, locked, ack;
  logic [2:0] device_select_code;
  logic [3:0] soft_write_protect;
  logic [7:0] rb [0:31];
  logic [7:0] e;
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 I_CLK = ~I_CLK;
  // Open-drain wire with pull-up
  assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
  esra_master m (.i_clk(I_CLK), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  esra_core #(.WRITE_CYCLE_CYCLES(WCC)) dut (
    .I_CLK(I_CLK),
    .I_RSTN(I_RSTN),
    .I_SCL(m_scl),
    .I_SDA(sda),
    .I_SERIAL_NUM(ser),
    .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe),
    .O_BUSY(busy),
    .O_DSC(device_select_code),
    .O_ID_LOCKED(locked),
    .O_SWP(soft_write_protect)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic idle();
    int n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge I_CLK);
      n++;
    end
    // A write cycle that never ends counts as a mismatch here
    check(8'(busy), 8'h00);
  endtask
  // One-byte write; ack holds the data acknowledge
  task automatic wr(input logic [6:0] dev, input logic [15:0] a, input logic [7:0] d, input bit w);
    logic k;
    m.start();
    m.wbyte({dev, 1'b0}, k);
    m.wbyte(a[15:8], k);
    m.wbyte(a[7:0], k);
    m.wbyte(d, ack);
    m.stop();
    if (w) idle();
  endtask
  task automatic cur(input logic [6:0] dev, input int n);
    logic k;
    m.start();
    m.wbyte({dev, 1'b1}, k);
    check(8'(k), 8'h01);
    for (int i = 0; i < n; i++) m.rbyte(i < n - 1, rb[i]);
    m.stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [15:0] a, input int n);
    logic k;
    m.start();
    m.wbyte({dev, 1'b0}, k);
    m.wbyte(a[15:8], k);
    m.wbyte(a[7:0], k);
    cur(dev, n);
  endtask
  task automatic t_reset();
    check(8'(device_select_code), 8'h00);
    check({4'h0, soft_write_protect}, 8'h00);
    check({6'h00, locked, busy}, 8'h00);
  endtask
  task automatic t_dsc();
    // Upper address bits set on purpose, they must not matter
    wr(7'h58, 16'hfc33, 8'hfd, 1);
    check(8'(device_select_code), 8'h05);
    rd(7'h5d, 16'h0c00, 2);
    check(rb[0], 8'h05);
    check(rb[1], 8'h05);
    m.start();
    m.wbyte(8'hb0, ack);
    m.stop();
    check(8'(ack), 8'h00);
  endtask
  task automatic t_array();
    wr(7'h55, 16'h0000, 8'h3c, 1);
    wr(7'h55, 16'h0001, 8'h5a, 1);
    wr(7'h55, 16'h3fff, 8'ha5, 0);
    m.start();
    m.wbyte(8'haa, ack);
    check({6'h00, ack, busy}, 8'h01);
    m.stop();
    idle();
    rd(7'h55, 16'h3fff, 2);
    check(rb[0], 8'ha5);
    check(rb[1], 8'h3c);
    cur(7'h55, 1);
    check(rb[0], 8'h5a);
  endtask
  task automatic t_serial();
    m.hp = 16;
    rd(7'h5d, 16'h080e, 19);
    m.hp = 10;
    for (int i = 0; i < 19; i++) begin
      e = (i < 2) ? 8'hce + 8'(i) : (i < 18) ? 8'h00 : 8'hc0;
      check(rb[i], e);
    end
    // Whole number from offset zero, exactly sixteen bytes
    rd(7'h5d, 16'h0800, 16);
    for (int i = 0; i < 16; i++) check(rb[i], ser[127 - 8 * i -: 8]);
  endtask
  task automatic t_swp();
    wr(7'h55, 16'h8000, 8'hf8, 1);
    check({4'h0, soft_write_protect}, 8'h08);
    rd(7'h55, 16'hc123, 3);
    for (int i = 0; i < 3; i++) check(rb[i], 8'h08);
  endtask
  task automatic t_id();
    wr(7'h5d, 16'h0005, 8'h77, 1);
    check(8'(ack), 8'h01);
    rd(7'h5d, 16'h0005, 1); // stays inside the page
    check(rb[0], 8'h77);
    wr(7'h5d, 16'h0400, 8'h02, 1);
    check(8'(locked), 8'h01);
    wr(7'h5d, 16'h0009, 8'h11, 1);
    check(8'(ack), 8'h00);
    wr(7'h5d, 16'h0c00, 8'h02, 1);
    check(8'(device_select_code), 8'h05);
  endtask
  initial begin
    repeat (20) @(negedge I_CLK);
    I_RSTN = 1'b1;
    repeat (8) @(negedge I_CLK);
    t_reset();
    t_dsc();
    t_array();
    t_serial();
    t_swp();
    t_id();
    wrap_up();
  end
  // About 2.7 times the expected run length
  initial begin
    #2500000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb
